/* File: tpcr_defs.vh */
`ifndef TPCR_DEFS_VH
`define TPCR_DEFS_VH

// Register offsets
`define TPCR_OFS_PATH 8'h0A
`define TPCR_OFS_EQ 8'h0B
`define TPCR_OFS_MOD 8'h0C
`define TPCR_OFS_DRV 8'h0D

// Reset values
`define TPCR_RST_PATH 8'h00
`define TPCR_RST_EQ 8'h00
`define TPCR_RST_MOD 8'h00
`define TPCR_RST_DRV 8'h00

// Implemented-bit masks, other bits read as zero
`define TPCR_MSK_PATH 8'hE3
`define TPCR_MSK_EQ 8'h4F
`define TPCR_MSK_MOD 8'hFF
`define TPCR_MSK_DRV 8'hFF

// Path control fields
`define TPCR_BIT_EXT_VSEL 0
`define TPCR_BIT_EQ_BYPASS 1
`define TPCR_BIT_OUT_INV 5
`define TPCR_BIT_DRV_OFF 6
`define TPCR_BIT_PATH_OFF 7

// Equalizer control fields
`define TPCR_EQS_MSB 3
`define TPCR_EQS_LSB 0
`define TPCR_BIT_PK_WIDE 6

// Output drive control fields
`define TPCR_DE_MSB 3
`define TPCR_DE_LSB 0
`define TPCR_BIT_SLOW 4
`define TPCR_BIT_DE_DLY 5
`define TPCR_BIT_SE_SEL 6
`define TPCR_BIT_NEG_SEL 7

// Serial byte length in bits
`define TPCR_BYTE_BITS 4'h8

`endif

/* File: tpcr_sync.v */
`timescale 1ns/1ps
module tpcr_sync
(
  input wire clk, // System clock
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable
  input wire [1:0] async_in, // Pin levels, unsynchronised
  output wire [1:0] sync_out // Synchronised levels
);

  reg [1:0] meta_ff; // First stage, read only by second
  reg [1:0] sync_ff; // Second stage

  // Two-flop synchroniser, idles high like a released bus
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
    end
    else if (ce)
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* File: tpcr_regs.v */
`timescale 1ns/1ps
`include "tpcr_defs.vh"
module tpcr_regs
#(
  parameter [6:0] DEV_ADDR = 7'h2A // Bus address, arbitrary value
)
(
  input wire clk, // System clock, 100 MHz
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable, freezes all state
  input wire sck_in, // Serial clock pin
  input wire sda_in, // Serial data pin level
  output wire sda_out, // Serial data drive value
  output wire sda_oe, // Serial data drive enable
  output wire eq_bypass, // Input equalizer bypassed
  output wire [3:0] eq_strength, // Equalization amount
  output wire eq_active, // Equalizer running
  output wire out_invert, // Output pair polarity swapped
  output wire driver_off, // Output driver disabled
  output wire single_ended_sel, // Single-ended output mode
  output wire negative_leg_sel, // Negative leg chosen
  output wire pos_leg_on, // Positive leg driving
  output wire neg_leg_on, // Negative leg driving
  output wire [3:0] deemph_level, // De-emphasis amount
  output wire peaking_width_wide, // Wide de-emphasis pulse
  output wire deemph_delayed, // Delayed de-emphasis timing
  output wire slow_edge, // Slow edge-rate mode
  output wire external_voltage_sel, // Amplitude from analog pin
  output wire [7:0] modulation_level, // Modulation level code
  output wire transmit_path_off // Whole path powered down
);

  // Serial engine states
  localparam [3:0] ST_IDLE = 4'h0; // Waiting for start
  localparam [3:0] ST_ADDR = 4'h1; // Receiving address byte
  localparam [3:0] ST_AACK = 4'h2; // Acknowledging address
  localparam [3:0] ST_PTR = 4'h3; // Receiving register pointer
  localparam [3:0] ST_PACK = 4'h4; // Acknowledging pointer
  localparam [3:0] ST_WDATA = 4'h5; // Receiving write data
  localparam [3:0] ST_WACK = 4'h6; // Acknowledging write data
  localparam [3:0] ST_RDATA = 4'h7; // Sending read data
  localparam [3:0] ST_RACK = 4'h8; // Sampling host acknowledge

  wire [1:0] pin_sync; // Synchronised pin levels
  wire sck_s; // Synchronised serial clock
  wire sda_s; // Synchronised serial data
  wire sck_rise; // Serial clock rising
  wire sck_fall; // Serial clock falling
  wire start_det; // Start or repeated start
  wire stop_det; // Stop condition
  wire byte_done; // Eighth bit seen
  wire wr_stb; // Register write strobe
  wire [7:0] rd_byte; // Read data at pointer

  reg sck_d_ff; // Previous serial clock
  reg sda_d_ff; // Previous serial data
  reg [3:0] state_ff; // Serial engine state
  reg [3:0] bit_cnt_ff; // Bits in current byte
  reg [7:0] shift_ff; // Byte shift register
  reg [7:0] ptr_ff; // Register pointer
  reg rw_ff; // Read transfer flag
  reg mack_ff; // Host acknowledged read byte
  reg sda_oe_ff; // Data drive enable
  reg sda_out_ff; // Data drive value, always low
  reg [7:0] path_ff; // Path control register
  reg [7:0] eq_ff; // Equalizer control register
  reg [7:0] mod_ff; // Modulation level register
  reg [7:0] drv_ff; // Output drive control register
  reg eq_active_ff; // Equalizer running
  reg pos_leg_on_ff; // Positive leg driving
  reg neg_leg_on_ff; // Negative leg driving

  // Readback of one register, unmapped offsets give zero
  function [7:0] rd_value;
    input [7:0] ofs;
    input [7:0] p_v;
    input [7:0] e_v;
    input [7:0] m_v;
    input [7:0] d_v;
    begin
      case (ofs)
        `TPCR_OFS_PATH: rd_value = p_v & `TPCR_MSK_PATH;
        `TPCR_OFS_EQ: rd_value = e_v & `TPCR_MSK_EQ;
        `TPCR_OFS_MOD: rd_value = m_v & `TPCR_MSK_MOD;
        `TPCR_OFS_DRV: rd_value = d_v & `TPCR_MSK_DRV;
        default: rd_value = 8'h00;
      endcase
    end
  endfunction

  // Merge of incoming byte, keeps only implemented bits
  function [7:0] wr_merge;
    input [7:0] data;
    input [7:0] mask;
    begin
      wr_merge = data & mask;
    end
  endfunction

  // Pin synchroniser for clock and data
  tpcr_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({sda_in, sck_in}),
    .sync_out(pin_sync)
  );

  assign sck_s = pin_sync[0];
  assign sda_s = pin_sync[1];

  // Edge and bus condition detection on synced levels
  assign sck_rise = sck_s & ~sck_d_ff;
  assign sck_fall = ~sck_s & sck_d_ff;
  assign start_det = sck_s & sck_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = sck_s & sck_d_ff & ~sda_d_ff & sda_s;
  assign byte_done = (bit_cnt_ff == `TPCR_BYTE_BITS);

  // Write happens at the falling edge after the eighth data bit
  assign wr_stb = (state_ff == ST_WDATA) & sck_fall & byte_done
                  & ~start_det & ~stop_det;
  // Byte about to be sent on a read
  assign rd_byte = rd_value(ptr_ff, path_ff, eq_ff, mod_ff, drv_ff);
  // Serial slave engine: address, pointer, data, acknowledge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sck_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end
    else if (ce)
    begin
      sck_d_ff <= sck_s;
      sda_d_ff <= sda_s;
      if (start_det)
      begin
        // Start, or repeated start, always restarts address phase
        state_ff <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end
      else if (stop_det)
      begin
        // Stop ends any transfer and frees the line
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ST_IDLE: sda_oe_ff <= 1'b0; // Nothing to do until a start
          ST_ADDR, ST_PTR, ST_WDATA:
          begin
            if (sck_rise)
            begin
              // Sample one bit, MSB first
              shift_ff <= {shift_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            else if (sck_fall && byte_done)
            begin
              bit_cnt_ff <= 4'h0;
              if (state_ff == ST_ADDR)
              begin
                if (shift_ff[7:1] == DEV_ADDR)
                begin
                  // Our address: acknowledge and note direction
                  rw_ff <= shift_ff[0];
                  sda_oe_ff <= 1'b1;
                  state_ff <= ST_AACK;
                end
                else
                begin
                  // Other device: stay off the line
                  state_ff <= ST_IDLE;
                end
              end
              else if (state_ff == ST_PTR)
              begin
                // Pointer byte selects the register
                ptr_ff <= shift_ff;
                sda_oe_ff <= 1'b1;
                state_ff <= ST_PACK;
              end
              else
              begin
                // Data byte written, pointer moves on
                ptr_ff <= ptr_ff + 8'h01;
                sda_oe_ff <= 1'b1;
                state_ff <= ST_WACK;
              end
            end
          end
          ST_AACK:
          begin
            if (sck_fall)
            begin
              if (rw_ff)
              begin
                // Read: load and drive the first bit
                shift_ff <= rd_byte;
                sda_oe_ff <= ~rd_byte[7];
                ptr_ff <= ptr_ff + 8'h01;
                bit_cnt_ff <= 4'h0;
                state_ff <= ST_RDATA;
              end
              else
              begin
                // Write: next byte is the pointer
                sda_oe_ff <= 1'b0;
                state_ff <= ST_PTR;
              end
            end
          end
          ST_PACK, ST_WACK:
          begin
            if (sck_fall)
            begin
              // Release after acknowledge, expect data
              sda_oe_ff <= 1'b0;
              state_ff <= ST_WDATA;
            end
          end
          ST_RDATA:
          begin
            if (sck_rise)
            begin
              // Host samples the bit now
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            else if (sck_fall)
            begin
              if (byte_done)
              begin
                // Byte sent, host owns the acknowledge slot
                sda_oe_ff <= 1'b0;
                state_ff <= ST_RACK;
              end
              else
              begin
                // Present the next bit, open-drain style
                shift_ff <= {shift_ff[6:0], 1'b0};
                sda_oe_ff <= ~shift_ff[6];
              end
            end
          end
          ST_RACK:
          begin
            if (sck_rise)
            begin
              // Low level means host wants more
              mack_ff <= ~sda_s;
            end
            else if (sck_fall)
            begin
              if (mack_ff)
              begin
                // Continue with the following register
                shift_ff <= rd_byte;
                sda_oe_ff <= ~rd_byte[7];
                ptr_ff <= ptr_ff + 8'h01;
                bit_cnt_ff <= 4'h0;
                state_ff <= ST_RDATA;
              end
              else
              begin
                // Not acknowledged: wait for stop
                sda_oe_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end
            end
          end
          default:
          begin
            // Recover from any stray code
            sda_oe_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Control register file, cleared at power-on reset
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      path_ff <= `TPCR_RST_PATH;
      eq_ff <= `TPCR_RST_EQ;
      mod_ff <= `TPCR_RST_MOD;
      drv_ff <= `TPCR_RST_DRV;
    end
    else if (ce && wr_stb)
    begin
      case (ptr_ff)
        `TPCR_OFS_PATH: path_ff <= wr_merge(shift_ff, `TPCR_MSK_PATH);
        `TPCR_OFS_EQ: eq_ff <= wr_merge(shift_ff, `TPCR_MSK_EQ);
        `TPCR_OFS_MOD: mod_ff <= wr_merge(shift_ff, `TPCR_MSK_MOD);
        `TPCR_OFS_DRV: drv_ff <= wr_merge(shift_ff, `TPCR_MSK_DRV);
        default: path_ff <= path_ff; // Unmapped offsets drop the write
      endcase
    end
  end

  // Derived enables, registered so outputs stay glitch free
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eq_active_ff <= 1'b0;
      pos_leg_on_ff <= 1'b0;
      neg_leg_on_ff <= 1'b0;
    end
    else if (ce)
    begin
      // Equalizer runs unless bypassed or path down
      eq_active_ff <= ~path_ff[`TPCR_BIT_EQ_BYPASS]
                      & ~path_ff[`TPCR_BIT_PATH_OFF];
      // With driver and path on: both legs in differential, one in single-ended
      pos_leg_on_ff <= ~path_ff[`TPCR_BIT_DRV_OFF]
                       & ~path_ff[`TPCR_BIT_PATH_OFF]
                       & (~drv_ff[`TPCR_BIT_SE_SEL]
                       | ~drv_ff[`TPCR_BIT_NEG_SEL]);
      neg_leg_on_ff <= ~path_ff[`TPCR_BIT_DRV_OFF]
                       & ~path_ff[`TPCR_BIT_PATH_OFF]
                       & (~drv_ff[`TPCR_BIT_SE_SEL]
                       | drv_ff[`TPCR_BIT_NEG_SEL]);
    end
  end

  // Serial line drive, value is fixed low
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;

  // Field outputs taken straight from register flops
  assign eq_bypass = path_ff[`TPCR_BIT_EQ_BYPASS];
  assign eq_strength = eq_ff[`TPCR_EQS_MSB:`TPCR_EQS_LSB];
  assign eq_active = eq_active_ff;
  assign out_invert = path_ff[`TPCR_BIT_OUT_INV];
  assign driver_off = path_ff[`TPCR_BIT_DRV_OFF];
  assign single_ended_sel = drv_ff[`TPCR_BIT_SE_SEL];
  assign negative_leg_sel = drv_ff[`TPCR_BIT_NEG_SEL];
  assign pos_leg_on = pos_leg_on_ff;
  assign neg_leg_on = neg_leg_on_ff;
  assign deemph_level = drv_ff[`TPCR_DE_MSB:`TPCR_DE_LSB];
  assign peaking_width_wide = eq_ff[`TPCR_BIT_PK_WIDE];
  assign deemph_delayed = drv_ff[`TPCR_BIT_DE_DLY];
  assign slow_edge = drv_ff[`TPCR_BIT_SLOW];
  assign external_voltage_sel = path_ff[`TPCR_BIT_EXT_VSEL];
  assign modulation_level = mod_ff;
  assign transmit_path_off = path_ff[`TPCR_BIT_PATH_OFF];

endmodule

/* File: tpcr_regs_chk.sv */
`timescale 1ns/1ps
// Watches the serial slave pins and the derived enables
module tpcr_regs_chk
(
  input wire clk, // System clock
  input wire rst, // Async reset
  input wire ce, // Clock enable
  input wire sck_in, // SCK pin
  input wire sda_out, // SDA drive value
  input wire sda_oe, // SDA pull enable
  input wire eq_bypass, // Equalizer bypass
  input wire eq_active, // Equalizer running
  input wire transmit_path_off, // Path down
  input wire driver_off, // Driver off
  input wire single_ended_sel, // Single-ended
  input wire negative_leg_sel, // Negative leg
  input wire pos_leg_on, // Positive leg on
  input wire neg_leg_on, // Negative leg on
  input wire [7:0] modulation_level // Level code
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // Open drain: never drives high
  property p_od;
    sda_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("SDA driven high");
  // Acknowledge starts only while SCK is low
  property p_ack;
    $rose(sda_oe) |-> !sck_in;
  endproperty
  a_ack: assert property (p_ack) else $error("SDA pulled in SCK high");
  // Pull is always released again
  property p_rel;
    $rose(sda_oe) |-> ##[1:300] !sda_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("SDA held too long");
  // Settings only change in the SCK low phase
  property p_upd;
    !$stable({transmit_path_off, driver_off, eq_bypass, modulation_level,
      single_ended_sel, negative_leg_sel}) |-> !sck_in;
  endproperty
  a_upd: assert property (p_upd) else $error("Setting changed in SCK high");
  // Equalizer runs unless bypassed or path down; derived flops lag reset by one edge
  property p_eq;
    $past(ce) && !$past(rst) |-> eq_active == $past(!eq_bypass && !transmit_path_off);
  endproperty
  a_eq: assert property (p_eq) else $error("Equalizer state wrong");
  // Positive leg drives unless driver off, path down or negative picked in single-ended
  property p_pos;
    $past(ce) && !$past(rst) |-> pos_leg_on == $past(!driver_off && !transmit_path_off &&
      (!single_ended_sel || !negative_leg_sel));
  endproperty
  a_pos: assert property (p_pos) else $error("Positive leg wrong");
  // Negative leg drives with driver and path on, in differential or when picked
  property p_neg;
    $past(ce) && !$past(rst) |-> neg_leg_on == $past(!driver_off && !transmit_path_off &&
      (!single_ended_sel || negative_leg_sel));
  endproperty
  a_neg: assert property (p_neg) else $error("Negative leg wrong");
  // Defaults right after reset
  property p_rstv;
    $past(rst) |-> !sda_oe && modulation_level == 8'h00 && !transmit_path_off
      && !driver_off && !eq_bypass;
  endproperty
  a_rstv: assert property (p_rstv) else $error("Reset state wrong");
endmodule
bind tpcr_regs tpcr_regs_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .sck_in(sck_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .eq_bypass(eq_bypass), .eq_active(eq_active),
  .transmit_path_off(transmit_path_off), .driver_off(driver_off),
  .single_ended_sel(single_ended_sel), .negative_leg_sel(negative_leg_sel),
  .pos_leg_on(pos_leg_on), .neg_leg_on(neg_leg_on), .modulation_level(modulation_level));

/* File: tpcr_host.sv */
`timescale 1ns/1ps
// Two-wire bus host, SDA only ever pulled low or released
module tpcr_host
#(
  parameter int Q = 6 // Clocks per quarter SCK period
)
(
  input wire clk, // System clock
  input wire sda_in, // Resolved SDA wire
  output logic sck, // SCK pin
  output logic sda_drv // Low pulls SDA, high releases
);
  // Idle bus
  initial
  begin
    sck = 1'b1;
    sda_drv = 1'b1;
  end
  // Wait clocks
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start or repeated start, leaves SCK low
  task automatic st();
    sda_drv <= 1'b1;
    tk(Q);
    sck <= 1'b1;
    tk(Q);
    sda_drv <= 1'b0;
    tk(Q);
    sck <= 1'b0;
    tk(Q);
  endtask
  // Stop, SDA rises while SCK high
  task automatic sp();
    sda_drv <= 1'b0;
    tk(Q);
    sck <= 1'b1;
    tk(Q);
    sda_drv <= 1'b1;
    tk(2 * Q);
  endtask
  // One bit: data set in SCK low, wire sampled mid SCK high
  task automatic bt(input logic v, output logic b);
    sda_drv <= v;
    tk(Q);
    sck <= 1'b1;
    tk(Q);
    b = sda_in;
    tk(Q);
    sck <= 1'b0;
    tk(Q);
  endtask
  // Byte out, MSB first, then acknowledge slot
  task automatic tx(input logic [7:0] d, output logic ok);
    logic b;
    for (int i = 7; i >= 0; i--)
      bt(d[i], b);
    bt(1'b1, b);
    ok = !b;
  endtask
  // Byte in, then host acknowledge or not
  task automatic rx(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
      bt(1'b1, d[i]);
    bt(last, b);
  endtask
  // Register write: address, pointer, data
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
      output logic ok);
    logic k1, k2, k3;
    st();
    tx({a, 1'b0}, k1);
    tx(o, k2);
    tx(d, k3);
    sp();
    ok = k1 & k2 & k3;
  endtask
  // Register read: pointer, repeated start, one byte
  task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
    logic k;
    st();
    tx({a, 1'b0}, k);
    tx(o, k);
    st();
    tx({a, 1'b1}, k);
    rx(1'b1, d);
    sp();
  endtask
endmodule

/* File: tpcr_regs_tb.sv */
`timescale 1ns/1ps
`include "tpcr_defs.vh"
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      num_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module tpcr_regs_tb;
  localparam logic [6:0] ADDR = 7'h2A; // Bus address, arbitrary value
  logic clk; // System clock
  logic rst; // Reset
  logic ce; // Clock enable
  wire sck, sda_drv, sda_out, sda_oe; // Bus pins
  wire sda; // Resolved SDA with pull-up
  wire eq_bypass, eq_active, out_invert, driver_off, single_ended_sel;
  wire negative_leg_sel, pos_leg_on, neg_leg_on, peaking_width_wide;
  wire deemph_delayed, slow_edge, external_voltage_sel, transmit_path_off;
  wire [3:0] eq_strength, deemph_level; // Four-bit fields
  wire [7:0] modulation_level; // Level code
  logic [7:0] r [0:3]; // Model of the four registers
  logic [7:0] msk [0:3]; // Stored bits per register
  int seed; // Random seed
  int num_errors = 0;
  int samples_checked = 0;
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  tpcr_regs #(.DEV_ADDR(ADDR)) DUT (.clk(clk), .rst(rst), .ce(ce), .sck_in(sck),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .eq_bypass(eq_bypass),
    .eq_strength(eq_strength), .eq_active(eq_active), .out_invert(out_invert),
    .driver_off(driver_off), .single_ended_sel(single_ended_sel),
    .negative_leg_sel(negative_leg_sel), .pos_leg_on(pos_leg_on),
    .neg_leg_on(neg_leg_on), .deemph_level(deemph_level),
    .peaking_width_wide(peaking_width_wide), .deemph_delayed(deemph_delayed),
    .slow_edge(slow_edge), .external_voltage_sel(external_voltage_sel),
    .modulation_level(modulation_level), .transmit_path_off(transmit_path_off));
  tpcr_host h (.clk(clk), .sda_in(sda), .sck(sck), .sda_drv(sda_drv));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts and verdict
  task automatic stop_test();
    $display("checked=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Every output against the model
  task automatic chk_out();
    h.tk(2);
    `CHK({external_voltage_sel, eq_bypass}, {r[0][0], r[0][1]})
    `CHK(eq_strength, r[1][3:0])
    `CHK({out_invert, driver_off, transmit_path_off}, {r[0][5], r[0][6], r[0][7]})
    `CHK(single_ended_sel, r[3][6])
    `CHK({negative_leg_sel, pos_leg_on, neg_leg_on}, {r[3][7],
      ~r[0][6] & ~r[0][7] & ~(r[3][6] & r[3][7]),
      ~r[0][6] & ~r[0][7] & (~r[3][6] | r[3][7])})
    `CHK(deemph_level, r[3][3:0])
    `CHK(peaking_width_wide, r[1][6])
    `CHK(deemph_delayed, r[3][5])
    `CHK(slow_edge, r[3][4])
    `CHK(modulation_level, r[2])
    `CHK(eq_active, ~r[0][1] & ~r[0][7])
  endtask
  // Write one register and check all outputs
  task automatic wreg(input int i, input logic [7:0] v);
    logic ok;
    h.wr(ADDR, i[7:0] + `TPCR_OFS_PATH, v, ok);
    `CHK(ok, 1'b1)
    r[i] = v & msk[i];
    chk_out();
  endtask
  // Read back all four registers
  task automatic rall();
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      h.rd(ADDR, i[7:0] + `TPCR_OFS_PATH, v);
      `CHK(v, r[i])
    end
  endtask
  // Hang guard
  initial
  begin
    repeat (99000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    logic [7:0] v [0:3];
    logic ok;
    logic [7:0] rv;
    int t;
    seed = 56337;
    rst <= 1'b1;
    ce <= 1'b1;
    msk = '{`TPCR_MSK_PATH, `TPCR_MSK_EQ, `TPCR_MSK_MOD, `TPCR_MSK_DRV};
    r = '{default: 8'h00};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    h.tk(3);
    chk_out();
    rall();
    // Walk a single one through every register
    for (int k = 0; k < 8; k++)
      for (int i = 0; i < 4; i++)
        wreg(i, 8'h01 << k[2:0]);
    rall();
    // Every leg select combination
    wreg(0, 8'h00);
    for (int j = 0; j < 4; j++)
      wreg(3, {j[1:0], 6'h00});
    // Random settings
    repeat (3)
    begin
      for (int i = 0; i < 4; i++)
      begin
        t = $random(seed);
        v[i] = t[7:0];
      end
      if (v[2] < 8'hC0)
        v[3][4] = 1'b1;
      wreg(3, v[3]);
      wreg(0, v[0]);
      wreg(1, v[1]);
      wreg(2, v[2]);
      rall();
    end
    // Wrong address is ignored
    h.wr(ADDR ^ 7'h01, 8'h0C, ~r[2], ok);
    `CHK(ok, 1'b0)
    chk_out();
    // Unmapped offset acked, reads zero
    h.wr(ADDR, 8'h0E, 8'hFF, ok);
    `CHK(ok, 1'b1)
    h.rd(ADDR, 8'h0E, rv);
    `CHK(rv, 8'h00)
    // Clock enable low: no acknowledge, no register change
    ce <= 1'b0;
    h.wr(ADDR, 8'h0C, ~r[2], ok);
    `CHK(ok, 1'b0)
    ce <= 1'b1;
    h.tk(3);
    chk_out();
    // Reset in mid-run
    rst <= 1'b1;
    h.tk(2);
    rst <= 1'b0;
    r = '{default: 8'h00};
    h.tk(3);
    chk_out();
    rall();
    stop_test();
  end
endmodule
